// ==== dv/dcr_host_model.sv ====
/*
 * dcr_host_model: host controller that writes whole register commands.
 * assumes: the bank takes a command at a rising edge with valid high.
 */
`timescale 1ns/1ns
module dcr_host_model (
   // clock
   input wire logic core_clk_i,
   // command port towards the bank
   output logic cmd_valid_o,
   output dcr_pkg::dcr_cmd_t cmd_o
);
   // ------------------------------------------------------------
   // idle state
   // ------------------------------------------------------------
   initial begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
   end
   // ------------------------------------------------------------
   // one register write
   // ------------------------------------------------------------
   // payload cut to the register's own length; once released the bus
   // shows the inverse so a stale value is never mistaken for a command
   task automatic send(input logic [7:0] addr, input logic [31:0] data, input int nbytes);
      @(negedge core_clk_i);
      cmd_valid_o = 1'b1;
      cmd_o.addr = addr;
      cmd_o.data = (nbytes == 4) ? data : data & ((32'h1 << (8 * nbytes)) - 32'h1);
      @(negedge core_clk_i);
      cmd_valid_o = 1'b0;
      cmd_o = ~cmd_o;
   endtask
endmodule

// ==== dv/tb_dcr_control_regs.sv ====
/*
 * tb_dcr_control_regs: self-checking bench for the control bank.
 * assumes: host model drives commands; bench drives detector inputs.
 */
`timescale 1ns/1ns
module tb_dcr_control_regs;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic core_clk_i, reset_n_i, cmd_valid, ext_present, ext_100, resp_valid;
   dcr_pkg::dcr_cmd_t cmd;
   logic [31:0] resp_data, tuning;
   logic [3:0][7:0] atten;
   logic [13:0] trim;
   logic led_on, analog_pwr_en, ref_bypass, osc_pwr_en, pll_lock_en, ref_10mhz, if_tap_en, tune_1mhz;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   // ------------------------------------------------------------
   // design and host
   // ------------------------------------------------------------
   dcr_control_regs DUT (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid),
      .cmd_i(cmd), .resp_valid_o(resp_valid), .resp_data_o(resp_data), .ext_ref_present_i(ext_present),
      .ext_ref_is_100mhz_i(ext_100), .led_on_o(led_on), .analog_pwr_en_o(analog_pwr_en),
      .rf_tuning_word_o(tuning), .atten_db_o(atten), .ref_bypass_o(ref_bypass), .osc_pwr_en_o(osc_pwr_en),
      .pll_lock_en_o(pll_lock_en), .ref_10mhz_o(ref_10mhz), .osc_trim_value_o(trim),
      .if_tap_en_o(if_tap_en), .tune_1mhz_o(tune_1mhz));
   dcr_host_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd));
   // ------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #4 core_clk_i = ~core_clk_i;
   end
   // the whole run needs under a hundred cycles; 5000 means a hang
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // compare and close
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // reset state: analog up, internal oscillator running, trim at midpoint
   task automatic t_reset();
      check("trim", 32'h2000, trim);
      check("analog", 32'h1, analog_pwr_en);
      check("tuning", 32'h0, tuning);
      check("osc", 32'h1, osc_pwr_en);
      $display("reset test done");
   endtask
   // led on then off, no answer ever comes back from a control write
   task automatic t_led();
      host.send(8'h02, 32'h01, 1);
      check("led", 32'h1, led_on);
      check("resp", 32'h0, resp_valid);
      host.send(8'h02, 32'h00, 1);
      check("led", 32'h0, led_on);
      $display("led test done");
   endtask
   // wide words, trim with reserved top bits set, monitor and step
   task automatic t_words();
      host.send(8'h10, 32'hA5C3_0F12, 4);
      check("tuning", 32'hA5C3_0F12, tuning);
      host.send(8'h15, 32'hFFFF, 2);
      check("trim", 32'h3FFF, trim);
      host.send(8'h16, 32'h01, 1);
      check("iftap", 32'h1, if_tap_en);
      host.send(8'h18, 32'h01, 1);
      check("step", 32'h1, tune_1mhz);
      host.send(8'h18, 32'h00, 1);
      check("step", 32'h0, tune_1mhz);
      $display("words test done");
   endtask
   // every attenuator of both channels, 0 to 30, then an over-range value
   task automatic t_atten();
      for (int i = 0; i < 4; i++) begin
         host.send(8'h12, {22'h0, 2'(i), 8'(i * 10)}, 2);
         check("atten", 32'(i * 10), atten[i]);
      end
      host.send(8'h12, 32'h001F, 2);
      check("clip", 32'h1E, atten[0]);
      $display("atten test done");
   endtask
   // all combinations of lock mode, presence and detected frequency
   task automatic t_ref();
      logic [2:0] k;
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         ext_present = k[1];
         ext_100 = k[2];
         host.send(8'h14, {29'h0, k[2], 1'b0, k[0]}, 1);
         check("bypass", !k[0] && k[1] && k[2], ref_bypass);
         check("osc", !(!k[0] && k[1] && k[2]), osc_pwr_en);
         check("lock", k[0] && k[1], pll_lock_en);
         check("r10", k[2], ref_10mhz);
      end
      ext_present = 1'b0;
      $display("ref test done");
   endtask
   // standby drops analog power, leaving it brings back the same word
   task automatic t_standby();
      host.send(8'h10, 32'h0000_1234, 4);
      host.send(8'h05, 32'h01, 1);
      check("analog", 32'h0, analog_pwr_en);
      host.send(8'h05, 32'h00, 1);
      check("analog", 32'h1, analog_pwr_en);
      check("tuning", 32'h1234, tuning);
      $display("standby test done");
   endtask
   // gain targets against the 60 dB ceiling, both signs and channels
   task automatic t_gain();
      logic [15:0] g [4] = '{16'h003C, 16'h8014, 16'h4005, 16'h8050};
      logic [7:0] e1 [4] = '{8'h00, 8'h1E, 8'h1E, 8'h00};
      logic [7:0] e2 [4] = '{8'h00, 8'h0A, 8'h1E, 8'h00};
      for (int i = 0; i < 4; i++) begin
         host.send(8'h17, {16'h0, g[i]}, 2);
         check("gain1", e1[i], atten[{g[i][15], 1'b0}]);
         check("gain2", e2[i], atten[{g[i][15], 1'b1}]);
      end
      $display("gain test done");
   endtask
   // query answers for exactly one cycle; an unmapped address does nothing
   task automatic t_query();
      host.send(8'h1A, 32'h00, 1);
      check("respv", 32'h1, resp_valid);
      check("respd", 32'h0000_0600, resp_data);
      @(negedge core_clk_i);
      check("respv", 32'h0, resp_valid);
      host.send(8'h20, 32'hFF, 1);
      check("resp", 32'h0, resp_valid);
      check("tuning", 32'h1234, tuning);
      $display("query test done");
   endtask
   // restore from standby with everything configured
   task automatic t_restore();
      host.send(8'h02, 32'h01, 1);
      host.send(8'h05, 32'h01, 1);
      host.send(8'h01, 32'h00, 1);
      check("analog", 32'h1, analog_pwr_en);
      check("tuning", 32'h0, tuning);
      check("trim", 32'h2000, trim);
      check("atten", 32'h0, atten);
      check("led", 32'h0, led_on);
      check("iftap", 32'h0, if_tap_en);
      $display("restore test done");
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset_n_i = 1'b0;
      ext_present = 1'b0;
      ext_100 = 1'b0;
      repeat (16) @(negedge core_clk_i);
      reset_n_i = 1'b1;
      t_reset();
      t_led();
      t_words();
      t_atten();
      t_ref();
      t_standby();
      t_gain();
      t_query();
      t_restore();
      end_of_test();
   end
endmodule

// ==== src/dcr_control_regs.sv ====
/*
 * dcr_control_regs: write-only control bank of a dual channel downconverter.
 * assumes: cmd_valid_i marks one whole register write, already deframed;
 * the reference detector inputs are synchronous to core_clk_i.
 */
// How it works
// [RQ1] control writes never return data
// [RQ2] query writes return one result word
// [RQ3] address 0x01 restores power-up configuration
// [RQ4] address 0x02 bit 0 drives LED
// [RQ5] standby bit one powers analog down
// [RQ6] standby clear restores retained configuration
// [RQ7] address 0x10 loads 32-bit tuning word
// [RQ8] attenuation in dB, limited to 30
// [RQ9] bits 8,9 pick attenuator and channel
// [RQ10] internal oscillator, bypassed by external 100 MHz
// [RQ11] only 100 MHz external may bypass
// [RQ12] mode bit one locks oscillator externally
// [RQ13] bit 2 picks 100 or 10 MHz
// [RQ14] address 0x15 loads 14-bit trim
// [RQ15] address 0x16 bit 0 enables IF taps
// [RQ16] gain target sets both channel attenuators
// [RQ17] bit 14 sign, bit 15 channel
// [RQ18] address 0x18 picks 5 or 1 MHz step
// [RQ19] host sends register-defined payload lengths
`timescale 1ns/1ns
module dcr_control_regs #(
   parameter logic [7:0] MAX_GAIN_DB = 8'h3C // gain with both attenuators at zero
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // command port
   input wire logic cmd_valid_i,
   input wire dcr_pkg::dcr_cmd_t cmd_i,
   // query answer
   output logic resp_valid_o,
   output logic [31:0] resp_data_o,
   // reference detector
   input wire logic ext_ref_present_i,
   input wire logic ext_ref_is_100mhz_i,
   // controls
   output logic led_on_o,
   output logic analog_pwr_en_o,
   output logic [31:0] rf_tuning_word_o,
   output logic [3:0][7:0] atten_db_o,
   output logic ref_bypass_o,
   output logic osc_pwr_en_o,
   output logic pll_lock_en_o,
   output logic ref_10mhz_o,
   output logic [13:0] osc_trim_value_o,
   output logic if_tap_en_o,
   output logic tune_1mhz_o
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // saturate a request to one attenuator's range
   function automatic logic [7:0] sat_atten(input logic [15:0] v);
      sat_atten = (v > 16'(dcr_pkg::ATTEN_MAX_DB)) ? dcr_pkg::ATTEN_MAX_DB : v[7:0];
   endfunction
   // total loss from target gain; negative targets need extra loss
   function automatic logic [15:0] gain_loss(input logic [15:0] p);
      logic [15:0] mag;
      mag = 16'(p[dcr_pkg::GAIN_W-1:0]);
      if (p[dcr_pkg::BIT_GAIN_NEG]) begin
         gain_loss = 16'(MAX_GAIN_DB) + mag;
      end else if (mag >= 16'(MAX_GAIN_DB)) begin
         gain_loss = 16'h0000; // nearest achievable is full gain
      end else begin
         gain_loss = 16'(MAX_GAIN_DB) - mag;
      end
   endfunction

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic [7:0] a; // address of the current write
   logic [31:0] d; // payload of the current write
   logic restore; // power-up restore strobe
   logic is_query;
   logic [15:0] loss; // total loss for a gain write
   logic [7:0] loss_a1;
   logic [7:0] loss_a2;
   assign a = cmd_i.addr;
   assign d = cmd_i.data;
   // payload byte is ignored, only the address matters
   assign restore = cmd_valid_i && (a == dcr_pkg::ADDR_POWER_UP_RESTORE); // RQ3
   assign is_query = cmd_valid_i && (a >= dcr_pkg::ADDR_QUERY_FIRST) && (a <= dcr_pkg::ADDR_QUERY_LAST);
   assign loss = gain_loss(d[15:0]); // RQ16 RQ17
   // fill attenuator one first, rest to attenuator two; saturation keeps nearest
   assign loss_a1 = sat_atten(loss); // RQ16
   assign loss_a2 = sat_atten(loss - 16'(loss_a1)); // RQ16

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic led_reg;
   logic standby_reg;
   logic [31:0] tuning_reg;
   logic [3:0][7:0] atten_reg; // index {channel, attenuator}
   dcr_pkg::dcr_ref_cfg_t ref_reg;
   logic [13:0] trim_reg;
   logic if_tap_reg;
   logic step_reg;
   logic resp_valid_reg;
   logic [31:0] resp_data_reg;

   // activity indicator
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         led_reg <= 1'b0;
      end else if (restore) begin
         led_reg <= 1'b0;
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_ACTIVITY_LED) begin
         led_reg <= d[dcr_pkg::BIT_ENABLE]; // RQ4
      end
   end

   // standby only gates power; configuration stays put so leaving restores it
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         standby_reg <= 1'b0;
      end else if (restore) begin
         standby_reg <= 1'b0;
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_LOW_POWER) begin
         standby_reg <= d[dcr_pkg::BIT_ENABLE]; // RQ5 RQ6
      end
   end

   // tuning word and step
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         tuning_reg <= dcr_pkg::RST_TUNING_WORD;
         step_reg <= 1'b0;
      end else if (restore) begin
         tuning_reg <= dcr_pkg::RST_TUNING_WORD;
         step_reg <= 1'b0;
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_RF_TUNING_WORD) begin
         tuning_reg <= d; // RQ7
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_TUNING_STEP) begin
         step_reg <= d[dcr_pkg::BIT_ENABLE]; // RQ18
      end
   end

   // attenuators: direct writes and gain targets share this store
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         atten_reg <= {4{dcr_pkg::RST_ATTEN}};
      end else if (restore) begin
         atten_reg <= {4{dcr_pkg::RST_ATTEN}};
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_ATTENUATOR) begin
         // out-of-range values are clipped rather than dropped
         atten_reg[{d[dcr_pkg::BIT_ATTEN_CH], d[dcr_pkg::BIT_ATTEN_NUM]}] <= sat_atten(16'(d[dcr_pkg::ATTEN_W-1:0])); // RQ8 RQ9
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_GAIN_TARGET) begin
         atten_reg[{d[dcr_pkg::BIT_GAIN_CH], 1'b0}] <= loss_a1; // RQ16 RQ17
         atten_reg[{d[dcr_pkg::BIT_GAIN_CH], 1'b1}] <= loss_a2; // RQ16 RQ17
      end
   end

   // reference mode, trim and monitor taps
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ref_reg <= '0;
         trim_reg <= dcr_pkg::RST_TRIM;
         if_tap_reg <= 1'b0;
      end else if (restore) begin
         ref_reg <= '0;
         trim_reg <= dcr_pkg::RST_TRIM;
         if_tap_reg <= 1'b0;
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_REF_SOURCE) begin
         ref_reg.use_pll <= d[dcr_pkg::BIT_REF_LOCK]; // RQ12
         ref_reg.ref_10mhz <= d[dcr_pkg::BIT_REF_10MHZ]; // RQ13
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_OSC_TRIM) begin
         trim_reg <= d[dcr_pkg::TRIM_W-1:0]; // RQ14
      end else if (cmd_valid_i && a == dcr_pkg::ADDR_IF_TAP) begin
         if_tap_reg <= d[dcr_pkg::BIT_ENABLE]; // RQ15
      end
   end

   // query answer: one word a cycle after the write, control writes stay silent
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         resp_valid_reg <= 1'b0;
         resp_data_reg <= 32'h0000_0000;
      end else begin
         resp_valid_reg <= is_query; // RQ1 RQ2
         if (is_query) begin
            // snapshot of mode flags, bit order of the status word
            resp_data_reg <= {16'h0000, ref_bypass_o, 1'b0, 1'b0, 1'b0, ext_ref_present_i,
                              ref_reg.use_pll, if_tap_reg, standby_reg, 8'h00}; // RQ2
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // only an external 100 MHz source may replace the oscillator outright
   assign ref_bypass_o = !ref_reg.use_pll && ext_ref_present_i && ext_ref_is_100mhz_i; // RQ10 RQ11
   assign osc_pwr_en_o = !ref_bypass_o; // RQ10
   assign pll_lock_en_o = ref_reg.use_pll && ext_ref_present_i; // RQ12
   assign ref_10mhz_o = ref_reg.ref_10mhz; // RQ13
   assign analog_pwr_en_o = !standby_reg; // RQ5
   assign led_on_o = led_reg;
   assign rf_tuning_word_o = tuning_reg;
   assign atten_db_o = atten_reg;
   assign osc_trim_value_o = trim_reg;
   assign if_tap_en_o = if_tap_reg;
   assign tune_1mhz_o = step_reg;
   assign resp_valid_o = resp_valid_reg;
   assign resp_data_o = resp_data_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_ctrl_write;
      cmd_valid_i && (cmd_i.addr < dcr_pkg::ADDR_QUERY_FIRST);
   endsequence
   sequence s_query_write;
      cmd_valid_i && (cmd_i.addr >= dcr_pkg::ADDR_QUERY_FIRST) && (cmd_i.addr <= dcr_pkg::ADDR_QUERY_LAST);
   endsequence
   property p_ctrl_silent;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_ctrl_write |=> !resp_valid_o;
   endproperty
   a_ctrl_silent: assert property (p_ctrl_silent) else $error("control write answered"); // RQ1
   property p_query_answer;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_query_write |=> resp_valid_o;
   endproperty
   a_query_answer: assert property (p_query_answer) else $error("query not answered"); // RQ2
   property p_restore;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_POWER_UP_RESTORE |=>
         !led_on_o && analog_pwr_en_o && osc_trim_value_o == dcr_pkg::RST_TRIM && atten_db_o == '0;
   endproperty
   a_restore: assert property (p_restore) else $error("restore incomplete"); // RQ3
   property p_led;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_ACTIVITY_LED |=> led_on_o == $past(cmd_i.data[0]);
   endproperty
   a_led: assert property (p_led) else $error("led mismatch"); // RQ4
   property p_standby_keeps;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_LOW_POWER |=>
         analog_pwr_en_o == !$past(cmd_i.data[0]) && rf_tuning_word_o == $past(rf_tuning_word_o);
   endproperty
   a_standby_keeps: assert property (p_standby_keeps) else $error("standby wrong"); // RQ5 RQ6
   property p_tuning;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_RF_TUNING_WORD |=> rf_tuning_word_o == $past(cmd_i.data);
   endproperty
   a_tuning: assert property (p_tuning) else $error("tuning word lost"); // RQ7
   property p_atten_range;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         atten_db_o[0] <= dcr_pkg::ATTEN_MAX_DB && atten_db_o[1] <= dcr_pkg::ATTEN_MAX_DB &&
         atten_db_o[2] <= dcr_pkg::ATTEN_MAX_DB && atten_db_o[3] <= dcr_pkg::ATTEN_MAX_DB;
   endproperty
   a_atten_range: assert property (p_atten_range) else $error("attenuator over range"); // RQ8
   property p_bypass_100;
      @(posedge core_clk_i) disable iff (!reset_n_i) ref_bypass_o |-> ext_ref_is_100mhz_i && !osc_pwr_en_o;
   endproperty
   a_bypass_100: assert property (p_bypass_100) else $error("bypass without 100 MHz"); // RQ10 RQ11
   property p_trim;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_OSC_TRIM |=> osc_trim_value_o == $past(cmd_i.data[13:0]);
   endproperty
   a_trim: assert property (p_trim) else $error("trim lost"); // RQ14
   // mode flags follow the last mode write; locking also needs a source present
   property p_ref_mode;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_REF_SOURCE |=>
         pll_lock_en_o == ($past(cmd_i.data[dcr_pkg::BIT_REF_LOCK]) && ext_ref_present_i) &&
         ref_10mhz_o == $past(cmd_i.data[dcr_pkg::BIT_REF_10MHZ]);
   endproperty
   a_ref_mode: assert property (p_ref_mode) else $error("reference mode wrong"); // RQ12 RQ13
   // lock mode must never pass the external source straight through
   property p_lock_no_bypass;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_REF_SOURCE && cmd_i.data[dcr_pkg::BIT_REF_LOCK] |=>
         !ref_bypass_o;
   endproperty
   a_lock_no_bypass: assert property (p_lock_no_bypass) else $error("lock mode bypassed"); // RQ11 RQ12
   // monitor taps follow bit 0 of their write
   property p_if_tap;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_IF_TAP |=>
         if_tap_en_o == $past(cmd_i.data[dcr_pkg::BIT_ENABLE]);
   endproperty
   a_if_tap: assert property (p_if_tap) else $error("monitor tap wrong"); // RQ15
   // step size follows bit 0 of its write
   property p_step;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_TUNING_STEP |=>
         tune_1mhz_o == $past(cmd_i.data[dcr_pkg::BIT_ENABLE]);
   endproperty
   a_step: assert property (p_step) else $error("step size wrong"); // RQ18
   // gain target aimed at channel one
   sequence s_gain_ch1;
      cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_GAIN_TARGET && !cmd_i.data[dcr_pkg::BIT_GAIN_CH];
   endsequence
   // positive channel one target whose loss both attenuators together can supply
   sequence s_gain_reachable;
      cmd_valid_i && cmd_i.addr == dcr_pkg::ADDR_GAIN_TARGET && !cmd_i.data[dcr_pkg::BIT_GAIN_CH] &&
      !cmd_i.data[dcr_pkg::BIT_GAIN_NEG] && 16'(cmd_i.data[dcr_pkg::GAIN_W-1:0]) <= 16'(MAX_GAIN_DB) &&
      16'(MAX_GAIN_DB) - 16'(cmd_i.data[dcr_pkg::GAIN_W-1:0]) <= 16'(2 * dcr_pkg::ATTEN_MAX_DB);
   endsequence
   property p_gain_ch1_only;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         s_gain_ch1 |=> atten_db_o[3:2] == $past(atten_db_o[3:2]);
   endproperty
   a_gain_ch1_only: assert property (p_gain_ch1_only) else $error("gain touched other channel"); // RQ17
   property p_gain_reach;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         s_gain_reachable |=>
         16'(atten_db_o[0]) + 16'(atten_db_o[1]) == 16'(MAX_GAIN_DB) - 16'($past(cmd_i.data[dcr_pkg::GAIN_W-1:0]));
   endproperty
   a_gain_reach: assert property (p_gain_reach) else $error("gain target missed"); // RQ16
endmodule

// ==== src/dcr_pkg.sv ====
/*
 * dcr_pkg: shared constants and carriers for the downconverter control bank.
 * assumes: one command port delivers an address with its payload, low byte first.
 */
package dcr_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_POWER_UP_RESTORE = 8'h01;
   localparam logic [7:0] ADDR_ACTIVITY_LED = 8'h02;
   localparam logic [7:0] ADDR_LOW_POWER = 8'h05;
   localparam logic [7:0] ADDR_RF_TUNING_WORD = 8'h10;
   localparam logic [7:0] ADDR_ATTENUATOR = 8'h12;
   localparam logic [7:0] ADDR_REF_SOURCE = 8'h14;
   localparam logic [7:0] ADDR_OSC_TRIM = 8'h15;
   localparam logic [7:0] ADDR_IF_TAP = 8'h16;
   localparam logic [7:0] ADDR_GAIN_TARGET = 8'h17;
   localparam logic [7:0] ADDR_TUNING_STEP = 8'h18;
   localparam logic [7:0] ADDR_QUERY_FIRST = 8'h19; // query space starts here
   localparam logic [7:0] ADDR_QUERY_LAST = 8'h1D;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE = 0;      // bit 0 of one-byte controls
   localparam int BIT_REF_LOCK = 0;
   localparam int BIT_REF_10MHZ = 2;
   localparam int BIT_ATTEN_NUM = 8;
   localparam int BIT_ATTEN_CH = 9;
   localparam int BIT_GAIN_NEG = 14;
   localparam int BIT_GAIN_CH = 15;
   localparam int ATTEN_W = 8;
   localparam int TRIM_W = 14;
   localparam int GAIN_W = 14;
   localparam logic [7:0] ATTEN_MAX_DB = 8'h1E; // one attenuator spans 0..30 dB
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_TUNING_WORD = 32'h0000_0000;
   localparam logic [13:0] RST_TRIM = 14'h2000;
   localparam logic [7:0] RST_ATTEN = 8'h00;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;   // register address
      logic [31:0] data;  // payload, unused upper bytes zero
   } dcr_cmd_t;
   typedef struct packed {
      logic use_pll;      // lock internal oscillator to external
      logic ref_10mhz;    // expected external frequency is 10 MHz
   } dcr_ref_cfg_t;
endpackage
